// ===== src/hbp_port_regs.vh
// register map, reset values and timing constants of the host bus port
`ifndef HBP_PORT_REGS_VH
`define HBP_PORT_REGS_VH
`define HBP_ADDR_W        19
`define HBP_GRPCTL_BASE   19'h40200
`define HBP_GRPCTL_LAST   19'h4027f
`define HBP_INCLK_ADDR    19'h40280
`define HBP_OUTCLK_ADDR   19'h40284
`define HBP_BLKINIT_ADDR  19'h40288
`define HBP_BLKEN_ADDR    19'h4028c
`define HBP_RATE_ADDR     19'h40290
`define HBP_CM_LAST       19'h27fff
`define HBP_DM_FIRST      19'h28000
`define HBP_DM_LAST       19'h2ffff
`define HBP_GRPCTL_RST    32'h000c000c
`define HBP_INCLK_RST     32'h000000db
`define HBP_OUTCLK_RST    32'h060d1c3c
`define HBP_RATE_RST      32'h00000000
`define HBP_GRP_IDX_HI    6
`define HBP_GRP_IDX_LO    2
`define HBP_INIT_TIME_US  1000
`define HBP_CLK_MHZ       50
`define HBP_INIT_CYCLES   (`HBP_INIT_TIME_US * `HBP_CLK_MHZ)
`define HBP_CM_INIT_WORDS 32
`define HBP_MCLK_TIMEOUT  16'h0010
`endif

// ===== src/hbp_host_port.v
// asynchronous handshake host port with reset defaults and connection memory init
//
// Behaviour
// - hold wait low, then ack or error
// - reads drive every lane of bus width
// - bad or data-store writes change nothing
// - strobe high returns ack and error high
// - chip select high floats lines, drives high first
// - second bus style always asserts transfer ack
// - narrow width ignores A0, A1 picks half
// - reset pin clears port and counters, loads register defaults
// - initialization completes about one millisecond
// - initialization zeroes connection memory by itself
// - group control registers reset to 000c000c
// - input clock control resets to 0db
// - output clock control resets to 060d1c3c
// - global rate control resets to 00
// - no master clock: answer bus error
// - narrow bus select picks 32 or 16
// - lane selection for writes only, reads full
// - narrow width: size lines are lane enables
`include "hbp_port_regs.vh"
`default_nettype none
module hbp_host_port #(
  parameter INIT_CYCLES = `HBP_INIT_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // host control pins
  input  wire        chipSelect_n,
  input  wire        dataStrobe_n,
  input  wire        readNotWrite,
  input  wire [18:0] address,
  input  wire [1:0]  xferSize,
  input  wire        narrowBusSelect,
  input  wire        busStyleSelect,
  // master clock input, judged present only while its synced level keeps toggling
  input  wire        masterClockIn,
  // data bus
  input  wire [31:0] dataIn,
  output reg  [31:0] dataOut,
  output reg         dataOe,
  // handshake outputs, active low, with enables
  output reg         transferAck_n,
  output reg         busErrorFlag_n,
  output reg         wait_n,
  output reg         ctrlOe,
  // status
  output reg         initDone
);

  // handshake sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_ACC  = 3'h2;
  localparam ST_RESP = 3'h3;
  localparam ST_HIGH = 3'h4;

  // synchronisers: first stage is read only by second stage
  reg [2:0] syncA;
  reg [2:0] syncB;
  reg [1:0] clkSync;
  wire      csAct = ~syncB[0];
  wire      dsAct = ~syncB[1];
  wire      rdAct = syncB[2];
  // bundled pins: address, size, data and straps, two flops each
  reg [18:0] addrSyncA;
  reg [18:0] addrSyncB;
  reg [1:0]  sizeSyncA;
  reg [1:0]  sizeSyncB;
  reg [31:0] dataSyncA;
  reg [31:0] dataSyncB;
  reg [1:0]  modeSyncA;
  reg [1:0]  modeSyncB;
  wire       narrowSync = modeSyncB[0];
  wire       styleSync  = modeSyncB[1];

  // sequencer state, register file and initialization bookkeeping
  reg [2:0]  state;
  reg [31:0] groupCtl [0:`HBP_CM_INIT_WORDS-1];
  reg [31:0] connMem  [0:`HBP_CM_INIT_WORDS-1];
  reg [31:0] inClkCtl;
  reg [31:0] outClkCtl;
  reg [31:0] rateCtl;
  reg [31:0] initCount;
  reg [5:0]  cmInitIdx;
  reg [15:0] mclkIdle;
  reg        mclkLast;
  reg        mclkOk;
  reg [18:0] addrLat;
  reg [1:0]  sizeLat;
  reg [31:0] wdataLat;
  reg        writeLat;
  integer    i;

  // byte lane enables for the word, msb lane first (bit 3 = 31:24)
  function [3:0] laneMask;
    input [1:0] a;
    input [1:0] s;
    input       narrow;
    input       byteEnStyle;
    reg   [3:0] m;
    begin
      m = 4'h0;
      if (narrow) begin
        // size lines are active-low lane enables, A1 picks half
        m = {~s[1], ~s[0], ~s[1], ~s[0]} & (a[1] ? 4'h3 : 4'hc);
      end else if (byteEnStyle) begin
        m = ~{a[1], a[0], s[1], s[0]};
      end else begin
        case (s)
          2'h1:    m = 4'h8 >> a;
          2'h2:    m = 4'hc >> a;
          2'h3:    m = 4'he >> a;
          default: m = 4'hf;
        endcase
      end
      laneMask = m;
    end
  endfunction

  // replace only the enabled byte lanes of a word
  function [31:0] mergeLanes;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  m;
    begin
      mergeLanes = {m[3] ? nw[31:24] : old[31:24], m[2] ? nw[23:16] : old[23:16],
                    m[1] ? nw[15:8] : old[15:8], m[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // decode on the word address latched at the start of a cycle
  wire [18:0] wordAddr = {addrLat[18:2], 2'h0};
  wire        isGroup  = (wordAddr >= `HBP_GRPCTL_BASE) && (wordAddr <= `HBP_GRPCTL_LAST);
  wire        isInClk  = (wordAddr == `HBP_INCLK_ADDR);
  wire        isOutClk = (wordAddr == `HBP_OUTCLK_ADDR);
  wire        isRate   = (wordAddr == `HBP_RATE_ADDR);
  wire        isInit   = (wordAddr == `HBP_BLKINIT_ADDR) || (wordAddr == `HBP_BLKEN_ADDR);
  wire        isConn   = (wordAddr <= `HBP_CM_LAST);
  wire        isData   = (wordAddr >= `HBP_DM_FIRST) && (wordAddr <= `HBP_DM_LAST);
  wire [4:0]  grpIdx   = addrLat[`HBP_GRP_IDX_HI:`HBP_GRP_IDX_LO];
  wire [4:0]  cmIdx    = addrLat[`HBP_GRP_IDX_HI:`HBP_GRP_IDX_LO];
  wire        valid    = isGroup | isInClk | isOutClk | isRate | isInit | isConn | (isData & ~writeLat);
  wire        okAccess = valid & mclkOk & initDone;
  wire [3:0]  mask     = laneMask(addrLat[1:0], sizeLat, narrowSync, styleSync);

  // read data selection; unmapped reads give zero (undefined per device)
  reg [31:0] readWord;
  always @* begin
    readWord = 32'h0;
    if (isGroup)       readWord = groupCtl[grpIdx];
    else if (isInClk)  readWord = inClkCtl;
    else if (isOutClk) readWord = outClkCtl;
    else if (isRate)   readWord = rateCtl;
    else if (isInit)   readWord = {31'h0, ~initDone};
    else if (isConn)   readWord = connMem[cmIdx];
  end

  // level inputs from the host pass two flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA   <= 3'h3;
      syncB   <= 3'h3;
      clkSync <= 2'h0;
    end else begin
      syncA   <= {readNotWrite, dataStrobe_n, chipSelect_n};
      syncB   <= syncA;
      clkSync <= {clkSync[0], masterClockIn};
    end
  end

  // bundled pins pass two flops too; the host sets them up before the strobe falls,
  // so the second stage has settled by the edge that sees the synced strobe low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addrSyncA <= 19'h0;
      addrSyncB <= 19'h0;
      sizeSyncA <= 2'h0;
      sizeSyncB <= 2'h0;
      dataSyncA <= 32'h0;
      dataSyncB <= 32'h0;
      modeSyncA <= 2'h0;
      modeSyncB <= 2'h0;
    end else begin
      addrSyncA <= address;
      addrSyncB <= addrSyncA;
      sizeSyncA <= xferSize;
      sizeSyncB <= sizeSyncA;
      dataSyncA <= dataIn;
      dataSyncB <= dataSyncA;
      modeSyncA <= {busStyleSelect, narrowBusSelect};
      modeSyncB <= modeSyncA;
    end
  end

  // master clock watchdog: no toggle within the window marks it absent
  // limitation: a master clock faster than half of clk aliases and may look stopped
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mclkLast <= 1'b0;
      mclkIdle <= 16'h0;
      mclkOk   <= 1'b0;
    end else begin
      mclkLast <= clkSync[1];
      if (mclkLast != clkSync[1]) begin
        mclkIdle <= 16'h0;
        mclkOk   <= 1'b1;
      end else if (mclkIdle == `HBP_MCLK_TIMEOUT) begin
        mclkOk   <= 1'b0;
      end else begin
        mclkIdle <= mclkIdle + 16'h1;
      end
    end
  end

  // initialization timer runs only while the master clock is seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      initCount <= 32'h0;
      initDone  <= 1'b0;
    end else if (!initDone && mclkOk) begin
      // done only once the timer has run out and the clearing walk covered every word
      if (initCount != INIT_CYCLES - 1)
        initCount <= initCount + 32'h1;
      else if (cmInitIdx == `HBP_CM_INIT_WORDS)
        initDone  <= 1'b1;
    end
  end

  // connection memory has no reset, like a block ram: only the clearing walk
  // zeroes it, one word per cycle while the master clock runs
  wire cmClearing = !initDone && mclkOk && (cmInitIdx < `HBP_CM_INIT_WORDS);
  wire hostWrite  = (state == ST_ACC) && writeLat && okAccess;
  always @(posedge clk) begin
    if (cmClearing) begin
      connMem[cmInitIdx[4:0]] <= 32'h0;
    end else if (hostWrite && isConn) begin
      // a host write never lands before the walk is over: okAccess needs initDone
      connMem[cmIdx] <= mergeLanes(connMem[cmIdx], wdataLat, mask);
    end
  end

  // register file: reset defaults, walk pointer, host writes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < `HBP_CM_INIT_WORDS; i = i + 1) begin
        groupCtl[i] <= `HBP_GRPCTL_RST;
      end
      inClkCtl  <= `HBP_INCLK_RST;
      outClkCtl <= `HBP_OUTCLK_RST;
      rateCtl   <= `HBP_RATE_RST;
      cmInitIdx <= 6'h0;
    end else if (!initDone) begin
      // the walk pointer moves only while the master clock is seen
      if (cmClearing)
        cmInitIdx <= cmInitIdx + 6'h1;
    end else if (hostWrite) begin
      // data store and unmapped writes fall through untouched
      if (isGroup)       groupCtl[grpIdx] <= mergeLanes(groupCtl[grpIdx], wdataLat, mask);
      else if (isInClk)  inClkCtl  <= mergeLanes(inClkCtl, wdataLat, mask);
      else if (isOutClk) outClkCtl <= mergeLanes(outClkCtl, wdataLat, mask);
      else if (isRate)   rateCtl   <= mergeLanes(rateCtl, wdataLat, mask);
    end
  end

  // handshake sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state          <= ST_IDLE;
      transferAck_n  <= 1'b1;
      busErrorFlag_n <= 1'b1;
      wait_n         <= 1'b1;
      ctrlOe         <= 1'b0;
      dataOe         <= 1'b0;
      dataOut        <= 32'h0;
      addrLat        <= 19'h0;
      sizeLat        <= 2'h0;
      wdataLat       <= 32'h0;
      writeLat       <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          transferAck_n  <= 1'b1;
          busErrorFlag_n <= 1'b1;
          wait_n         <= 1'b1;
          ctrlOe         <= csAct;
          // read data stays on the bus until select rises or a new strobe comes
          dataOe         <= dataOe & csAct & ~dsAct;
          if (csAct && dsAct) begin
            // host keeps address and data stable while strobe is low
            addrLat  <= addrSyncB;
            sizeLat  <= sizeSyncB;
            wdataLat <= narrowSync ? {dataSyncB[15:0], dataSyncB[15:0]} : dataSyncB;
            writeLat <= ~rdAct;
            wait_n   <= 1'b0;
            ctrlOe   <= 1'b1;
            state    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // spare cycle: leaves room for a slower store behind the decode
          state <= ST_ACC;
        end
        ST_ACC: begin
          if (!writeLat) begin
            // whole word on every lane; narrow mode picks half by A1
            dataOut <= narrowSync ? (addrLat[1] ? {16'h0, readWord[15:0]}
                                                : {16'h0, readWord[31:16]}) : readWord;
            dataOe  <= 1'b1;
          end
          state <= ST_RESP;
        end
        ST_RESP: begin
          // answer lines move in the same cycle as wait is released
          wait_n         <= 1'b1;
          busErrorFlag_n <= okAccess;
          transferAck_n  <= ~(okAccess | styleSync);
          state          <= ST_HIGH;
        end
        ST_HIGH: begin
          if (!csAct) begin
            // drive inactive for this cycle, then float in idle
            transferAck_n  <= 1'b1;
            busErrorFlag_n <= 1'b1;
            wait_n         <= 1'b1;
            dataOe         <= 1'b0;
            state          <= ST_IDLE;
          end else if (!dsAct) begin
            transferAck_n  <= 1'b1;
            busErrorFlag_n <= 1'b1;
            state          <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/hbp_host_port_properties.sv
// concurrent checks on the host port handshake pins
`default_nettype none
module hbp_host_port_checker #(
  parameter INIT_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host pins
  input wire logic chipSelect_n,
  input wire logic dataStrobe_n,
  input wire logic readNotWrite,
  input wire logic busStyleSelect,
  // device answers
  input wire logic dataOe,
  input wire logic transferAck_n,
  input wire logic busErrorFlag_n,
  input wire logic wait_n,
  input wire logic ctrlOe,
  input wire logic initDone
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // wait spans the access, then exactly one answer step
  sequence s_hold; !wait_n [*3]; endsequence
  sequence s_answer; wait_n && (!transferAck_n || !busErrorFlag_n); endsequence
  property p_waitLen; $fell(wait_n) |-> s_hold ##1 s_answer; endproperty
  a_waitLen: assert property (p_waitLen) else $error("wait span or answer wrong");
  property p_style; busStyleSelect && !busErrorFlag_n |-> !transferAck_n; endproperty
  a_style: assert property (p_style) else $error("error without ack in second style");
  property p_excl; !busStyleSelect && !busErrorFlag_n |-> transferAck_n; endproperty
  a_excl: assert property (p_excl) else $error("ack and error together");
  property p_release; $rose(dataStrobe_n) && !chipSelect_n |-> ##[1:4] (transferAck_n && busErrorFlag_n); endproperty
  a_release: assert property (p_release) else $error("answer not withdrawn");
  property p_float; $rose(chipSelect_n) |-> ##[1:5] (!ctrlOe && !dataOe); endproperty
  a_float: assert property (p_float) else $error("lines not floated");
  property p_highFirst; $fell(ctrlOe) |-> $past(transferAck_n) && $past(busErrorFlag_n) && $past(wait_n); endproperty
  a_highFirst: assert property (p_highFirst) else $error("floated while low");
  property p_readOe; $rose(dataOe) |-> readNotWrite && ctrlOe && !wait_n ##1 s_answer; endproperty
  a_readOe: assert property (p_readOe) else $error("read data not before answer");
  property p_early; $fell(wait_n) && !initDone |-> ##3 !busErrorFlag_n; endproperty
  a_early: assert property (p_early) else $error("access before init not refused");
endmodule
bind hbp_host_port hbp_host_port_checker #(.INIT_CYCLES(INIT_CYCLES)) u_checker (
  .clk(clk), .resetn(resetn), .chipSelect_n(chipSelect_n), .dataStrobe_n(dataStrobe_n),
  .readNotWrite(readNotWrite), .busStyleSelect(busStyleSelect), .dataOe(dataOe),
  .transferAck_n(transferAck_n), .busErrorFlag_n(busErrorFlag_n), .wait_n(wait_n),
  .ctrlOe(ctrlOe), .initDone(initDone));
`default_nettype wire

// ===== tb/hbp_host_model.sv
// host processor model driving the strobe handshake
`default_nettype none
module hbp_host_model (
  // clock and answers
  input  wire logic        clk,
  input  wire logic        transferAck_n,
  input  wire logic        busErrorFlag_n,
  // host pins
  output var  logic        chipSelect_n,
  output var  logic        dataStrobe_n,
  output var  logic        readNotWrite,
  output var  logic [18:0] address,
  output var  logic [1:0]  xferSize,
  output var  logic [31:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle host: deselected, strobe high
  initial begin
    chipSelect_n = 1'b1;
    dataStrobe_n = 1'b1;
    readNotWrite = 1'b1;
    address = 19'h0;
    xferSize = 2'h0;
    dataIn = 32'h0;
  end
  // one bus cycle; csEarly lifts the select before the strobe
  task automatic access(input logic rd, input logic [18:0] a, input logic [1:0] sz,
                        input logic [31:0] d, input logic csEarly);
    int n;
    @(negedge clk);
    readNotWrite = rd;
    address = a;
    xferSize = sz;
    chipSelect_n = 1'b0;
    if (!rd)
      dataIn = d;
    @(negedge clk);
    dataStrobe_n = 1'b0;
    n = 0;
    // hold all pins until an answer shows, bounded so a dead port cannot hang us
    while (transferAck_n && busErrorFlag_n && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (csEarly) begin
      chipSelect_n = 1'b1;
      @(negedge clk);
    end
    dataStrobe_n = 1'b1;
    repeat (4) @(negedge clk);
    chipSelect_n = 1'b1;
    dataIn = ~dataIn; // released bus must not keep its last value
    repeat (3) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_host_bus_port_handshake.sv
// self-checking bench for the host bus port handshake
`include "hbp_port_regs.vh"
`default_nettype none
module tb_host_bus_port_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] grpBase = `HBP_GRPCTL_BASE;
  logic        clk, resetn, narrowBusSelect, busStyleSelect, masterClockIn, mclkRun, prevAns;
  wire         chipSelect_n, dataStrobe_n, readNotWrite, dataOe, transferAck_n, busErrorFlag_n;
  wire         wait_n, ctrlOe, initDone;
  wire [18:0]  address;
  wire [1:0]   xferSize;
  wire [31:0]  dataIn, dataOut;
  logic [34:0] notes[$];
  logic [34:0] e;
  logic [31:0] v, w;
  int          miscompares, n_checks, seed;
  hbp_host_port #(.INIT_CYCLES(8)) DUT (.clk(clk), .resetn(resetn), .chipSelect_n(chipSelect_n),
    .dataStrobe_n(dataStrobe_n), .readNotWrite(readNotWrite), .address(address), .xferSize(xferSize),
    .narrowBusSelect(narrowBusSelect), .busStyleSelect(busStyleSelect), .masterClockIn(masterClockIn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .transferAck_n(transferAck_n),
    .busErrorFlag_n(busErrorFlag_n), .wait_n(wait_n), .ctrlOe(ctrlOe), .initDone(initDone));
  hbp_host_model host (.clk(clk), .transferAck_n(transferAck_n), .busErrorFlag_n(busErrorFlag_n),
    .chipSelect_n(chipSelect_n), .dataStrobe_n(dataStrobe_n), .readNotWrite(readNotWrite),
    .address(address), .xferSize(xferSize), .dataIn(dataIn));
  // system clock and a slower, unrelated master clock that can be stopped
  always #10 clk = ~clk;
  always #30 if (mclkRun) masterClockIn = ~masterClockIn;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // notes: {read, ack level, error level, data}
  task rd(input logic [18:0] a, input logic [31:0] exp);
    notes.push_back({1'b1, 1'b0, 1'b1, exp});
    host.access(1'b1, a, 2'b00, 32'h0, 1'b0);
  endtask
  task wr(input logic [18:0] a, input logic [1:0] sz, input logic [31:0] d);
    notes.push_back({1'b0, 1'b0, 1'b1, 32'h0});
    host.access(1'b0, a, sz, d, 1'b0);
  endtask
  // refused access: data is undefined, so only the answer lines count
  task bad(input logic r, input logic [18:0] a);
    notes.push_back({1'b0, ~busStyleSelect, 1'b0, 32'h0});
    host.access(r, a, 2'b00, $random(seed), 1'b0);
  endtask
  task waitInit;
    repeat (200) if (!initDone) @(negedge clk);
  endtask
  // first cycle of every answer is compared against the oldest note
  always @(negedge clk) begin
    if (resetn && ctrlOe && !(transferAck_n && busErrorFlag_n) && !prevAns) begin
      e = notes.size() > 0 ? notes.pop_front() : 35'h0;
      check("ack", transferAck_n, e[33]);
      check("error", busErrorFlag_n, e[32]);
      if (e[34])
        check("data", dataOut, e[31:0]);
    end
    prevAns = ctrlOe && !(transferAck_n && busErrorFlag_n);
  end
  initial begin
    seed = 2940;
    clk = 0;
    masterClockIn = 0;
    mclkRun = 1;
    resetn = 0;
    narrowBusSelect = 0;
    busStyleSelect = 0;
    prevAns = 0;
    repeat (16) @(negedge clk);
    resetn = 1;
    bad(1'b1, grpBase);
    waitInit;
    rd(grpBase, `HBP_GRPCTL_RST);
    rd(`HBP_GRPCTL_LAST - 19'h3, `HBP_GRPCTL_RST);
    rd(`HBP_INCLK_ADDR, `HBP_INCLK_RST);
    rd(`HBP_OUTCLK_ADDR, `HBP_OUTCLK_RST);
    rd(`HBP_RATE_ADDR, `HBP_RATE_RST);
    rd(19'h00100, 32'h0);
    v = $random(seed);
    wr(grpBase, 2'b00, v);
    rd(grpBase, v);
    w = $random(seed);
    wr(grpBase + 19'h1, 2'b01, w);
    v[23:16] = w[23:16];
    bad(1'b0, `HBP_DM_FIRST);
    bad(1'b0, 19'h30000);
    rd(grpBase, v);
    bad(1'b1, 19'h40294);
    busStyleSelect = 1;
    bad(1'b1, 19'h30000);
    w = $random(seed);
    wr(grpBase + 19'h4, 2'b00, w);
    rd(grpBase + 19'h4, w);
    busStyleSelect = 0;
    narrowBusSelect = 1;
    rd(`HBP_OUTCLK_ADDR, 32'h0000060d);
    rd(`HBP_OUTCLK_ADDR + 19'h3, 32'h00001c3c);
    w = $random(seed);
    wr(grpBase + 19'h2, 2'b10, w);
    v[7:0] = w[7:0];
    narrowBusSelect = 0;
    rd(grpBase, v);
    notes.push_back({1'b1, 1'b0, 1'b1, v});
    host.access(1'b1, grpBase, 2'b00, 32'h0, 1'b1);
    mclkRun = 0;
    repeat (30) @(negedge clk);
    bad(1'b1, grpBase);
    mclkRun = 1;
    repeat (30) @(negedge clk);
    wr(19'h00100, 2'b00, $random(seed));
    wr(grpBase, 2'b00, $random(seed));
    resetn = 0;
    repeat (3) @(negedge clk);
    resetn = 1;
    waitInit;
    rd(19'h00100, 32'h0);
    rd(grpBase, `HBP_GRPCTL_RST);
    repeat (5) @(negedge clk);
    check("pending", notes.size(), 32'h0);
    conclude;
  end
  // hang guard: the full sequence needs well under this span
  initial begin
    #100us;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire
